//--- rtl/dnac_pkg.sv
// Package for the dual nibble converter control block
package dnac_pkg;
   localparam logic [11:0] ADDR_RESULT_ENABLE = 12'h020;
   localparam logic [11:0] ADDR_STATUS = 12'h024;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam int ENABLE_BIT_CH0 = 0;
   localparam int ENABLE_BIT_CH1 = 1;
   localparam int NIBBLE_W = 4;
   localparam int RESULT_LO = 0;
   localparam int RESULT_HI = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int CLK_HZ = 250_000_000;
   // Sample rate in millihertz, 488.3 Hz as printed
   localparam int SAMPLE_RATE_MHZ = 488_300;
   localparam longint SAMPLE_CYCLES = (longint'(CLK_HZ) * 1000) / SAMPLE_RATE_MHZ;
   localparam int TICK_W = 20;

   typedef struct packed {
      logic [NIBBLE_W-1:0] ch1;
      logic [NIBBLE_W-1:0] ch0;
   } dnac_result_s;

   typedef enum logic {DNAC_RD_IDLE, DNAC_RD_RESP} dnac_rd_e;
   typedef enum logic [1:0] {DNAC_WR_IDLE, DNAC_WR_RESP} dnac_wr_e;
endpackage : dnac_pkg

//--- rtl/dnac_top.sv
// Dual nibble converter control with AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite interface to the registers.
module dnac_top
   import dnac_pkg::*;
#(
   parameter int unsigned SAMPLE_PERIOD = int'(SAMPLE_CYCLES)
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [NIBBLE_W-1:0] conv_data_ch0_i,
   input wire logic [NIBBLE_W-1:0] conv_data_ch1_i,
   output logic [1:0] adc_route_o,
   output logic [1:0] sample_strobe_o
);

   function automatic logic [1:0] decode(input logic [11:0] a);
      decode = {a == ADDR_STATUS, a == ADDR_RESULT_ENABLE};
   endfunction : decode

   // Three-stage synchronisers for the asynchronous converter codes
   logic [7:0] sync1_r, sync2_r, sync3_r;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         sync3_r <= 8'h00;
      end else begin
         sync1_r <= {conv_data_ch1_i, conv_data_ch0_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // State
   logic [1:0] enable_r, enable_nxt;
   dnac_result_s result_r, result_nxt;
   logic [TICK_W-1:0] tick_r, tick_nxt;
   logic [1:0] strobe_r, strobe_nxt;
   logic [7:0] stable_r, stable_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   // Readies are flops too, so every bus output leaves a register
   logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
   logic wr_fire;
   logic [1:0] wr_sel, rd_sel;

   always_comb begin
      // Sample timebase; samples only while enabled
      tick_nxt = tick_r + TICK_W'(1);
      strobe_nxt = 2'b00;
      if (tick_r >= TICK_W'(SAMPLE_PERIOD - 1)) begin
         tick_nxt = '0;
         strobe_nxt = enable_r;
      end
      // Only agreed codes (stages two and three) are taken
      stable_nxt = (sync2_r == sync3_r) ? sync3_r : stable_r;
      result_nxt = result_r;
      if (strobe_r[ENABLE_BIT_CH0]) begin
         result_nxt.ch0 = stable_r[NIBBLE_W-1:0];
      end
      if (strobe_r[ENABLE_BIT_CH1]) begin
         result_nxt.ch1 = stable_r[2*NIBBLE_W-1:NIBBLE_W];
      end
   end

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      enable_nxt = enable_r;
      if (s_axi_awvalid_i && !aw_got_r && !bvalid_r) begin
         aw_got_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_got_r && !bvalid_r) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_i;
         wstrb_nxt = s_axi_wstrb_i;
      end
      wr_fire = aw_got_r && w_got_r && !bvalid_r;
      wr_sel = decode(awaddr_r);
      if (wr_fire) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wr_sel != 2'b00) ? RESP_OKAY : RESP_SLVERR;
         // Write reaches enables only; results untouched
         if (wr_sel[0] && wstrb_r[0]) begin
            enable_nxt = wdata_r[1:0];
         end
      end
      if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
      end
      // Next readies follow the next held and pending state
      awready_nxt = !aw_got_nxt && !bvalid_nxt;
      wready_nxt = !w_got_nxt && !bvalid_nxt;
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rd_sel = decode(s_axi_araddr_i);
      if (s_axi_arvalid_i && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = (rd_sel != 2'b00) ? RESP_OKAY : RESP_SLVERR;
         rdata_nxt = '0;
         if (rd_sel[0]) begin
            rdata_nxt[7:0] = result_r;
         end
         if (rd_sel[1]) begin
            rdata_nxt[1:0] = enable_r;
         end
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         enable_r <= ENABLE_RESET[1:0];
         result_r <= '0;
         tick_r <= '0;
         strobe_r <= 2'b00;
         stable_r <= 8'h00;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
      end else begin
         enable_r <= enable_nxt;
         result_r <= result_nxt;
         tick_r <= tick_nxt;
         strobe_r <= strobe_nxt;
         stable_r <= stable_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
      end
   end

   // Ready flags are registers: low while a beat is held
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign adc_route_o = enable_r;
   assign sample_strobe_o = strobe_r;

   property p_reset_off;
      @(posedge clk_sys_i) $rose(arst_n_i) |-> enable_r == 2'b00;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("enables not clear after reset");

   property p_strobe_enabled;
      @(posedge clk_sys_i) disable iff (!arst_n_i) (strobe_r & ~$past(enable_r)) == 2'b00;
   endproperty
   a_strobe_enabled: assert property (p_strobe_enabled) else $error("sample on disabled channel");

   property p_hold_ch0;
      @(posedge clk_sys_i) disable iff (!arst_n_i) !strobe_r[0] |=> $stable(result_r.ch0);
   endproperty
   a_hold_ch0: assert property (p_hold_ch0) else $error("channel 0 result moved without sample");

   property p_hold_ch1;
      @(posedge clk_sys_i) disable iff (!arst_n_i) !strobe_r[1] |=> $stable(result_r.ch1);
   endproperty
   a_hold_ch1: assert property (p_hold_ch1) else $error("channel 1 result moved without sample");

   property p_load_ch0;
      @(posedge clk_sys_i) disable iff (!arst_n_i) strobe_r[0] |=> result_r.ch0 == $past(stable_r[3:0]);
   endproperty
   a_load_ch0: assert property (p_load_ch0) else $error("channel 0 result not loaded");

   property p_write_en;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (wr_fire && awaddr_r == ADDR_RESULT_ENABLE && wstrb_r[0]) |=> enable_r == $past(wdata_r[1:0]);
   endproperty
   a_write_en: assert property (p_write_en) else $error("enable write lost");

   property p_write_no_result;
      @(posedge clk_sys_i) disable iff (!arst_n_i) (wr_fire && strobe_r == 2'b00) |=> $stable(result_r);
   endproperty
   a_write_no_result: assert property (p_write_no_result) else $error("write disturbed results");

   property p_read_pack;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (s_axi_arvalid_i && !rvalid_r && s_axi_araddr_i == ADDR_RESULT_ENABLE)
         |=> rvalid_r && rdata_r == {24'h000000, $past(result_r)};
   endproperty
   a_read_pack: assert property (p_read_pack) else $error("read data not packed results");

   // Routing only moves on an accepted enable write with lane 0 on
   property p_route_hold;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         !(wr_fire && wr_sel[0] && wstrb_r[0]) |=> $stable(adc_route_o);
   endproperty
   a_route_hold: assert property (p_route_hold) else $error("route moved without enable write");

   property p_load_ch1;
      @(posedge clk_sys_i) disable iff (!arst_n_i) strobe_r[1] |=> result_r.ch1 == $past(stable_r[7:4]);
   endproperty
   a_load_ch1: assert property (p_load_ch1) else $error("channel 1 result not loaded");

   // Timebase never runs past one sample period
   property p_tick_bound;
      @(posedge clk_sys_i) disable iff (!arst_n_i) tick_r < TICK_W'(SAMPLE_PERIOD);
   endproperty
   a_tick_bound: assert property (p_tick_bound) else $error("sample timebase overran");

   // Every wrap samples exactly the channels enabled then
   property p_strobe_due;
      @(posedge clk_sys_i) disable iff (!arst_n_i) tick_r == TICK_W'(SAMPLE_PERIOD - 1) |=> strobe_r == $past(enable_r);
   endproperty
   a_strobe_due: assert property (p_strobe_due) else $error("sample missing at period end");

   property p_strobe_single;
      @(posedge clk_sys_i) disable iff (!arst_n_i) strobe_r != 2'b00 |=> strobe_r == 2'b00;
   endproperty
   a_strobe_single: assert property (p_strobe_single) else $error("sample strobe longer than one cycle");

   // Unmapped reads answer with an error and no data
   property p_rd_unmapped;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         (s_axi_arvalid_i && s_axi_arready_o && decode(s_axi_araddr_i) == 2'b00)
         |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h00000000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");

   property p_wr_resp;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
         wr_fire |=> s_axi_bvalid_o && s_axi_bresp_o == (($past(wr_sel) == 2'b00) ? RESP_SLVERR : RESP_OKAY);
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");

   property p_ready_block;
      @(posedge clk_sys_i) disable iff (!arst_n_i) s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_ready_block: assert property (p_ready_block) else $error("write accepted while response pending");

   property p_reset_route;
      @(posedge clk_sys_i) $rose(arst_n_i) |-> adc_route_o == ENABLE_RESET[1:0] && sample_strobe_o == 2'b00;
   endproperty
   a_reset_route: assert property (p_reset_route) else $error("pins not plain I/O after reset");

   c_write: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) wr_fire && wr_sel[0]);
   c_hold: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) !enable_r[0] && result_r.ch0 != '0);
   c_read: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) s_axi_rvalid_o && s_axi_rready_i);
   c_sample: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) strobe_r == 2'b11);
endmodule : dnac_top

//--- testbench/dnac_tb_top.sv
// Self-checking bench for the dual nibble converter control block
module dnac_tb_top;
   import dnac_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SP = 20;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, cd0 = 4'h0, cd1 = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, route, strobe;
   int bad_count = 0;
   int cmp_count = 0;

   dnac_top #(.SAMPLE_PERIOD(SP)) u_dnac_top (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .conv_data_ch0_i(cd0), .conv_data_ch1_i(cd1),
      .adc_route_o(route), .sample_strobe_o(strobe)
   );

   always #2 clk_sys_i = ~clk_sys_i;

   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: data got %h expected %h", $time, g, e);
      end
   endtask : chk_data

   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: resp got %h expected %h", $time, g, e);
      end
   endtask : chk_resp

   task automatic chk_bits(input logic [1:0] g, input logic [1:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: enables got %h expected %h", $time, g, e);
      end
   endtask : chk_bits

   task automatic chk_count(input int g, input int e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: count got %h expected %h", $time, g, e);
      end
   endtask : chk_count

   // Entry waits an edge so a bready lowered by the last call is never re-raised in the same step
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int k;
      @(posedge clk_sys_i);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         k++;
      end while (bvalid !== 1'b1 && k < 100);
      r = bresp;
      bready <= 1'b0;
      if (k >= 100) bad_count++;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         k++;
      end while (rvalid !== 1'b1 && k < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (k >= 100) bad_count++;
   endtask : rd

   task automatic wrap_up();
      $display("Comparisons %0d, errors %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // Whole run is under two thousand cycles
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end

   initial begin
      int tbl[5] = '{1, 3, 2, 0, 3};
      int seed, v, n0, n1, m0, m1;
      int exp_q[$];
      logic [31:0] d;
      logic [1:0] r, en, en_m;
      seed = 32'hEF20;
      m0 = 0;
      m1 = 0;
      en_m = ENABLE_RESET[1:0];
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      rd(ADDR_RESULT_ENABLE, d, r);
      chk_data(d, 32'h0);
      chk_resp(r, RESP_OKAY);
      chk_bits(route, en_m);
      foreach (tbl[i]) begin
         en = tbl[i][1:0];
         v = $random(seed);
         cd0 <= v[3:0];
         cd1 <= v[7:4];
         // Upper write bits random: they must not leak into the enables
         wr(ADDR_RESULT_ENABLE, {v[31:2], en}, 4'hF, r);
         chk_resp(r, RESP_OKAY);
         en_m = en;
         if (en_m[0]) m0 = v & 32'h0000000F;
         if (en_m[1]) m1 = (v >> 4) & 32'h0000000F;
         exp_q.push_back((m1 << 4) | m0);
         repeat (3 * SP) @(posedge clk_sys_i);
         chk_bits(route, en_m);
         n0 = 0;
         n1 = 0;
         repeat (10 * SP) begin
            @(posedge clk_sys_i);
            n0 += int'(strobe[0] === 1'b1);
            n1 += int'(strobe[1] === 1'b1);
         end
         chk_count(n0, 10 * int'(en_m[0]));
         chk_count(n1, 10 * int'(en_m[1]));
         rd(ADDR_RESULT_ENABLE, d, r);
         chk_data(d, exp_q.pop_front());
         chk_resp(r, RESP_OKAY);
         rd(ADDR_STATUS, d, r);
         chk_data(d, {30'h0, en_m});
      end
      // Lane 0 off, readback address and a hole must all leave the enables alone
      wr(ADDR_RESULT_ENABLE, 32'h0, 4'hE, r);
      chk_resp(r, RESP_OKAY);
      chk_bits(route, en_m);
      wr(ADDR_STATUS, 32'h0, 4'hF, r);
      chk_resp(r, RESP_OKAY);
      wr(12'h028, 32'h0, 4'hF, r);
      chk_resp(r, RESP_SLVERR);
      chk_bits(route, en_m);
      rd(12'h028, d, r);
      chk_resp(r, RESP_SLVERR);
      chk_data(d, 32'h0);
      @(posedge clk_sys_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      en_m = ENABLE_RESET[1:0];
      rd(ADDR_STATUS, d, r);
      chk_data(d, 32'(ENABLE_RESET));
      chk_bits(route, en_m);
      wrap_up();
   end
endmodule : dnac_tb_top
